// ---- rtl/mafg_pkg.sv ----
package mafg_pkg;

  // Register offsets
  localparam logic [7:0] OFF_CONVERTER_CONFIG    = 8'h10;
  localparam logic [7:0] OFF_FALSE_ALARM_CONFIG  = 8'h11;
  localparam logic [7:0] OFF_PIN_FUNCTION_CONFIG = 8'h12;
  localparam logic [7:0] OFF_INPUT_MUX_CONFIG_2  = 8'h15;
  localparam logic [7:0] OFF_CONVERTER_RANGE_0   = 8'h1E;
  localparam logic [7:0] OFF_CONVERTER_RANGE_1   = 8'h1F;
  localparam logic [7:0] OFF_TEMPERATURE_LOW     = 8'h78;
  localparam logic [7:0] OFF_TEMPERATURE_HIGH    = 8'h79;
  localparam logic [7:0] OFF_PIN_DATA            = 8'h7A;

  // Reset values
  localparam logic [7:0] RST_CONVERTER_CONFIG    = 8'h00;
  localparam logic [7:0] RST_FALSE_ALARM_CONFIG  = 8'h00;
  localparam logic [7:0] RST_PIN_FUNCTION_CONFIG = 8'h00;
  localparam logic [7:0] RST_INPUT_MUX_CONFIG_2  = 8'h01;
  localparam logic [7:0] RST_PIN_DATA            = 8'hFF;
  localparam logic [11:0] RST_TEMPERATURE        = 12'h000;

  // Field positions
  localparam int BIT_AUTO_MODE       = 0;
  localparam int BIT_REF_BUFFER_EN   = 1;
  localparam int BIT_SOFT_TRIGGER    = 2;
  localparam int BIT_TEMP_ENABLE     = 0;
  localparam int LSB_UNIPOLAR_FACTOR = 0;
  localparam int LSB_TEMP_FACTOR     = 4;
  localparam int LSB_GROUP_EVEN      = 0;
  localparam int LSB_GROUP_ODD       = 4;
  localparam logic [7:0] MASK_PIN_FUNCTION = 8'h0F;
  localparam logic [7:0] MASK_CONVERTER    = 8'h03;
  localparam logic [7:0] MASK_MUX_CONFIG_2 = 8'h01;
  localparam logic [7:0] MASK_RANGE        = 8'h77;

  // Pins with an alternate function
  localparam int PIN_ALARM_IN  = 0;
  localparam int PIN_ALARM_OUT = 1;
  localparam int PIN_TRIGGER   = 2;
  localparam int PIN_DATA_AVL  = 3;

  // Sizes
  localparam int PIN_COUNT      = 8;
  localparam int MONITOR_COUNT  = 6;
  localparam int LIMIT_COUNT    = 12;
  localparam int GROUP_COUNT    = 4;
  localparam int RANGE_WIDTH    = 3;
  localparam int FACTOR_WIDTH   = 4;
  localparam int COUNT_WIDTH    = 5;
  localparam logic [2:0] CHANNEL_TEMP = 3'h5;

  // Range codes
  localparam logic [2:0] RANGE_POS_10V = 3'h6;
  localparam logic [2:0] RANGE_NEG_5V  = 3'h5;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } seq_state_t;

endpackage : mafg_pkg

// ---- rtl/alarm_filter_if.sv ----
`timescale 1ns/1ps
interface alarm_filter_if;
  logic [3:0] factorM1;
  logic       sample;
  logic       outOfRange;
  logic       alarmEvent;
  logic       alarmActive;

  modport filter (
    input  factorM1,
    input  sample,
    input  outOfRange,
    output alarmEvent,
    output alarmActive
  );

  modport owner (
    output factorM1,
    output sample,
    output outOfRange,
    input  alarmEvent,
    input  alarmActive
  );
endinterface : alarm_filter_if

// ---- rtl/alarm_filter_counter.sv ----
`timescale 1ns/1ps
module alarm_filter_counter (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic          clkEn,
  // Filter link
  alarm_filter_if.filter     link
);

  logic [mafg_pkg::COUNT_WIDTH-1:0] count_reg;
  logic                             event_reg;
  logic                             active_reg;
  logic [mafg_pkg::COUNT_WIDTH-1:0] target;

  assign target = {1'b0, link.factorM1} + 5'h01;
  assign link.alarmEvent = event_reg;
  assign link.alarmActive = active_reg;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_reg  <= '0;
      event_reg  <= 1'b0;
      active_reg <= 1'b0;
    end else if (clkEn) begin
      event_reg <= 1'b0;
      if (link.sample) begin
        if (!link.outOfRange) begin
          count_reg  <= '0;
          active_reg <= 1'b0;
        end else if (count_reg < target) begin
          count_reg <= count_reg + 5'h01;
          if (count_reg + 5'h01 == target) begin
            event_reg  <= 1'b1;
            active_reg <= 1'b1;
          end
        end
      end
    end
  end

endmodule : alarm_filter_counter

// ---- rtl/monitor_alarm_filter_gpio.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Alarm only after N consecutive out-of-range results.
// - N programmable in false alarm register.
// - Temperature channel disabled by mux config bit.
// - Disabled temperature channel skipped, not converted.
// - Auto mode continuous, direct mode per trigger.
// - Temperature stored 12-bit two's complement, two registers.
// - Reference buffer off after reset, software enables.
// - Low four pins: plain pin or alternate.
// - Alarm in, alarm out, trigger, data available.
// - Upper four pins always plain pins.
// - Output pin follows pin data bit.
// - Pin data read returns live input level.
// - Pin data resets to all ones.
// - Four converter groups, independent range and clamp.
// - Range code 110b selects zero to ten volts.
// - Range code 101b selects minus five to zero.
module monitor_alarm_filter_gpio (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  output logic             regRdValid,
  // Converter side
  input  wire logic        convValid,
  input  wire logic [2:0]  convChannel,
  input  wire logic        convAboveHigh,
  input  wire logic        convBelowLow,
  input  wire logic [11:0] convData,
  input  wire logic        convDone,
  output logic             convStart,
  output logic             tempChannelEnable,
  output logic             refBufferEnable,
  output logic [11:0]      alarmEvents,
  output logic             clearRequest,
  // Group range and clamp
  input  wire logic [11:0] rangeStrap,
  output logic      [11:0] groupRange,
  output logic      [11:0] groupClamp,
  // General pins
  input  wire logic [7:0]  generalPinIn,
  output logic      [7:0]  generalPinOut,
  output logic      [7:0]  generalPinOe
);

  logic [7:0]  convCfg_reg;
  logic [7:0]  falseAlarm_reg;
  logic [7:0]  pinFunc_reg;
  logic [7:0]  muxCfg_reg;
  logic [7:0]  pinData_reg;
  logic [11:0] tempData_reg;
  logic [11:0] range_reg;
  logic [11:0] clamp_reg;
  logic        dataAvail_reg;
  logic        trigPrev_reg;
  logic        softTrig_reg;
  logic        start_reg;
  logic        global_alarm_output_reg;
  logic        clearReq_reg;
  logic [11:0] events_reg;
  logic [7:0]  rdData_reg;
  logic        rdValid_reg;
  logic [7:0]  oe_reg;
  mafg_pkg::seq_state_t state_reg;

  mafg_pkg::seq_state_t seqNext;
  logic        wrConv;
  logic        tempRead;
  logic        extTrig;
  logic        trigger;
  logic        startNext;
  logic        tempEn;
  logic        autoMode;
  logic        anyActive;
  logic [11:0] eventVec;
  logic [11:0] activeVec;
  logic [7:0]  rdMux;
  logic [7:0]  pinView;
  logic [7:0]  oeNext;

  assign tempEn   = muxCfg_reg[mafg_pkg::BIT_TEMP_ENABLE];
  assign autoMode = convCfg_reg[mafg_pkg::BIT_AUTO_MODE];
  assign wrConv   = regWrEn && regAddr == mafg_pkg::OFF_CONVERTER_CONFIG;
  assign tempRead = regRdEn && (regAddr == mafg_pkg::OFF_TEMPERATURE_LOW ||
                                regAddr == mafg_pkg::OFF_TEMPERATURE_HIGH);
  assign extTrig  = pinFunc_reg[mafg_pkg::PIN_TRIGGER] && trigPrev_reg &&
                    !generalPinIn[mafg_pkg::PIN_TRIGGER];
  assign trigger  = extTrig || softTrig_reg;
  assign anyActive = |activeVec;

  // One filter per monitored input and limit
  genvar gi;
  generate
    for (gi = 0; gi < mafg_pkg::LIMIT_COUNT; gi++) begin : gFilter
      alarm_filter_if fIf ();
      localparam logic [2:0] CH = 3'(gi / 2);
      assign fIf.factorM1 = (CH == mafg_pkg::CHANNEL_TEMP) ?
        falseAlarm_reg[mafg_pkg::LSB_TEMP_FACTOR +: 4] :
        falseAlarm_reg[mafg_pkg::LSB_UNIPOLAR_FACTOR +: 4];
      // Results of a disabled sensor are ignored
      assign fIf.sample = convValid && convChannel == CH &&
        (CH != mafg_pkg::CHANNEL_TEMP || tempEn);
      assign fIf.outOfRange = (gi % 2 == 0) ? convAboveHigh : convBelowLow;
      assign eventVec[gi]  = fIf.alarmEvent;
      assign activeVec[gi] = fIf.alarmActive;
      alarm_filter_counter uFilter (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .link    (fIf.filter)
      );
    end
  endgenerate

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      convCfg_reg    <= mafg_pkg::RST_CONVERTER_CONFIG;
      falseAlarm_reg <= mafg_pkg::RST_FALSE_ALARM_CONFIG;
      pinFunc_reg    <= mafg_pkg::RST_PIN_FUNCTION_CONFIG;
      muxCfg_reg     <= mafg_pkg::RST_INPUT_MUX_CONFIG_2;
      softTrig_reg   <= 1'b0;
    end else if (clkEn) begin
      softTrig_reg <= wrConv && regWrData[mafg_pkg::BIT_SOFT_TRIGGER];
      if (wrConv) begin
        convCfg_reg <= regWrData & mafg_pkg::MASK_CONVERTER;
      end
      if (regWrEn && regAddr == mafg_pkg::OFF_FALSE_ALARM_CONFIG) begin
        falseAlarm_reg <= regWrData;
      end
      if (regWrEn && regAddr == mafg_pkg::OFF_PIN_FUNCTION_CONFIG) begin
        pinFunc_reg <= regWrData & mafg_pkg::MASK_PIN_FUNCTION;
      end
      if (regWrEn && regAddr == mafg_pkg::OFF_INPUT_MUX_CONFIG_2) begin
        muxCfg_reg <= regWrData & mafg_pkg::MASK_MUX_CONFIG_2;
      end
    end
  end

  // Group range and clamp; strap caught at reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      range_reg <= rangeStrap;
      clamp_reg <= rangeStrap;
    end else if (clkEn) begin
      if (regWrEn && regAddr == mafg_pkg::OFF_CONVERTER_RANGE_0) begin
        range_reg[0 +: 3] <= regWrData[mafg_pkg::LSB_GROUP_EVEN +: 3];
        range_reg[3 +: 3] <= regWrData[mafg_pkg::LSB_GROUP_ODD +: 3];
      end
      if (regWrEn && regAddr == mafg_pkg::OFF_CONVERTER_RANGE_1) begin
        range_reg[6 +: 3] <= regWrData[mafg_pkg::LSB_GROUP_EVEN +: 3];
        range_reg[9 +: 3] <= regWrData[mafg_pkg::LSB_GROUP_ODD +: 3];
      end
    end
  end

  // Conversion sequencer
  always_comb begin
    seqNext   = state_reg;
    startNext = 1'b0;
    case (state_reg)
      mafg_pkg::SEQ_IDLE: begin
        if (autoMode || trigger) begin
          seqNext   = mafg_pkg::SEQ_RUN;
          startNext = 1'b1;
        end
      end
      mafg_pkg::SEQ_RUN: begin
        if (convDone) begin
          if (autoMode) begin
            startNext = 1'b1;
          end else begin
            seqNext = mafg_pkg::SEQ_IDLE;
          end
        end
      end
      default: begin
        seqNext = mafg_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= mafg_pkg::SEQ_IDLE;
      start_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= seqNext;
      start_reg <= startNext;
    end
  end

  // Data available: completion beats clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dataAvail_reg <= 1'b0;
    end else if (clkEn) begin
      if (state_reg == mafg_pkg::SEQ_RUN && convDone && !autoMode) begin
        dataAvail_reg <= 1'b1;
      end else if (startNext || tempRead) begin
        dataAvail_reg <= 1'b0;
      end
    end
  end

  // Temperature result
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tempData_reg <= mafg_pkg::RST_TEMPERATURE;
    end else if (clkEn) begin
      if (convValid && convChannel == mafg_pkg::CHANNEL_TEMP && tempEn) begin
        tempData_reg <= convData;
      end
    end
  end

  // Pin data register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinData_reg <= mafg_pkg::RST_PIN_DATA;
    end else if (clkEn) begin
      if (regWrEn && regAddr == mafg_pkg::OFF_PIN_DATA) begin
        pinData_reg <= regWrData;
      end
    end
  end

  // Pin drive: open drain, low only
  always_comb begin
    oeNext = ~pinData_reg;
    if (pinFunc_reg[mafg_pkg::PIN_ALARM_IN]) begin
      oeNext[mafg_pkg::PIN_ALARM_IN] = 1'b0;
    end
    if (pinFunc_reg[mafg_pkg::PIN_ALARM_OUT]) begin
      oeNext[mafg_pkg::PIN_ALARM_OUT] = global_alarm_output_reg;
    end
    if (pinFunc_reg[mafg_pkg::PIN_TRIGGER]) begin
      oeNext[mafg_pkg::PIN_TRIGGER] = 1'b0;
    end
    if (pinFunc_reg[mafg_pkg::PIN_DATA_AVL]) begin
      oeNext[mafg_pkg::PIN_DATA_AVL] = dataAvail_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      oe_reg       <= '0;
      trigPrev_reg <= 1'b1;
      global_alarm_output_reg <= 1'b0;
      clearReq_reg <= 1'b0;
      events_reg   <= '0;
    end else if (clkEn) begin
      oe_reg       <= oeNext;
      trigPrev_reg <= generalPinIn[mafg_pkg::PIN_TRIGGER];
      global_alarm_output_reg <= anyActive;
      clearReq_reg <= pinFunc_reg[mafg_pkg::PIN_ALARM_IN] &&
                      !generalPinIn[mafg_pkg::PIN_ALARM_IN];
      events_reg   <= eventVec;
    end
  end

  // A bit written 1 reads the pin; a driven bit reads itself
  assign pinView = (pinData_reg & generalPinIn) |
                   (pinFunc_reg & generalPinIn);

  always_comb begin
    case (regAddr)
      mafg_pkg::OFF_CONVERTER_CONFIG:    rdMux = convCfg_reg;
      mafg_pkg::OFF_FALSE_ALARM_CONFIG:  rdMux = falseAlarm_reg;
      mafg_pkg::OFF_PIN_FUNCTION_CONFIG: rdMux = pinFunc_reg;
      mafg_pkg::OFF_INPUT_MUX_CONFIG_2:  rdMux = muxCfg_reg;
      mafg_pkg::OFF_CONVERTER_RANGE_0:
        rdMux = {1'b0, range_reg[3 +: 3], 1'b0, range_reg[0 +: 3]};
      mafg_pkg::OFF_CONVERTER_RANGE_1:
        rdMux = {1'b0, range_reg[9 +: 3], 1'b0, range_reg[6 +: 3]};
      mafg_pkg::OFF_TEMPERATURE_LOW:     rdMux = tempData_reg[7:0];
      mafg_pkg::OFF_TEMPERATURE_HIGH:
        rdMux = {4'h0, tempData_reg[11:8]};
      mafg_pkg::OFF_PIN_DATA:            rdMux = pinView;
      default:                           rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdData_reg  <= 8'h00;
      rdValid_reg <= 1'b0;
    end else if (clkEn) begin
      rdValid_reg <= regRdEn;
      if (regRdEn) begin
        rdData_reg <= rdMux;
      end
    end
  end

  assign regRdData         = rdData_reg;
  assign regRdValid        = rdValid_reg;
  assign convStart         = start_reg;
  assign tempChannelEnable = muxCfg_reg[mafg_pkg::BIT_TEMP_ENABLE];
  assign refBufferEnable   = convCfg_reg[mafg_pkg::BIT_REF_BUFFER_EN];
  assign alarmEvents       = events_reg;
  assign clearRequest      = clearReq_reg;
  assign groupRange        = range_reg;
  assign groupClamp        = clamp_reg;
  assign generalPinOut     = 8'h00;
  assign generalPinOe      = oe_reg;

endmodule : monitor_alarm_filter_gpio

// ---- tb/pin_pullup_model.sv ----
`timescale 1ns/1ps
module pin_pullup_model (
  // Device side
  input  wire logic [7:0] generalPinOe,
  // Board side
  input  wire logic [7:0] extLow,
  output logic      [7:0] generalPinIn
);
  // Released pins float up to the pull-up, any driver wins low
  assign generalPinIn = ~(generalPinOe | extLow);
endmodule : pin_pullup_model

// ---- tb/mafg_chk.sv ----
`timescale 1ns/1ps
module mafg_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWrEn,
  input wire logic [7:0]  regWrData,
  input wire logic        regRdEn,
  input wire logic        regRdValid,
  // Converter and pins
  input wire logic        convValid,
  input wire logic [2:0]  convChannel,
  input wire logic        convAboveHigh,
  input wire logic        convBelowLow,
  input wire logic        convStart,
  input wire logic        tempChannelEnable,
  input wire logic        refBufferEnable,
  input wire logic [11:0] alarmEvents,
  input wire logic        clearRequest,
  input wire logic [7:0]  generalPinIn,
  input wire logic [7:0]  generalPinOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_ref_off: assert property (
    $past(sys_rst) |-> !refBufferEnable) else $error("ref buffer on");
  chk_pins_released: assert property (
    $past(sys_rst) |-> generalPinOe == 8'h00) else $error("pin driven");
  chk_ref_enable: assert property (
    clkEn && regWrEn && regAddr == 8'h10 && regWrData[1]
    |=> ##[0:1] refBufferEnable) else $error("ref buffer stays off");
  chk_temp_disable: assert property (
    clkEn && regWrEn && regAddr == 8'h15 && !regWrData[0]
    |=> ##[0:1] !tempChannelEnable) else $error("temp stays on");
  chk_read_valid: assert property (
    clkEn && regRdEn |=> regRdValid) else $error("no read valid");
  chk_event_cause: assert property (
    |alarmEvents |-> $past(clkEn && convValid
    && (convAboveHigh || convBelowLow), 2)) else $error("stray event");
  chk_event_pulse: assert property (
    (alarmEvents & $past(alarmEvents)) == 12'h000)
    else $error("event longer than a cycle");
  chk_temp_skip: assert property (
    clkEn && convValid && convChannel == 3'h5 && !tempChannelEnable
    |-> ##2 alarmEvents[11:10] == 2'b00) else $error("temp not skipped");
  chk_start_pulse: assert property (
    convStart |=> !convStart) else $error("start too long");
  chk_clear_level: assert property (
    clearRequest |-> !$past(generalPinIn[0])) else $error("clear w/o pin");

  cov_event: cover property (|alarmEvents);
  cov_start: cover property (convStart);
  cov_clear: cover property (clearRequest);
endmodule : mafg_chk

bind monitor_alarm_filter_gpio mafg_chk u_chk (.sys_clk, .sys_rst,
  .clkEn, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdValid,
  .convValid, .convChannel, .convAboveHigh, .convBelowLow, .convStart,
  .tempChannelEnable, .refBufferEnable, .alarmEvents, .clearRequest,
  .generalPinIn, .generalPinOe);

// ---- tb/monitor_alarm_filter_gpio_bench.sv ----
`timescale 1ns/1ps
module monitor_alarm_filter_gpio_bench;
  localparam logic [7:0] OFFS [6] = '{8'h10,8'h11,8'h12,8'h15,8'h7A,8'h00};
  localparam logic [7:0] RSTS [6] = '{8'h00,8'h00,8'h00,8'h01,8'hFF,8'h00};
  // Channel, above, below: ch1 streak broken once, ch2 interleaved
  localparam logic [4:0] SEQ [9] = '{5'h06, 5'h06, 5'h04, 5'h06, 5'h09,
                                     5'h06, 5'h08, 5'h06, 5'h09};
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clkEn = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic        regWrEn = 1'b0;
  logic [7:0]  regWrData = 8'h00;
  logic        regRdEn = 1'b0;
  logic [7:0]  regRdData;
  logic        regRdValid;
  logic        convValid = 1'b0;
  logic [2:0]  convChannel = 3'h0;
  logic        convAboveHigh = 1'b0;
  logic        convBelowLow = 1'b0;
  logic [11:0] convData = 12'h000;
  logic        convDone = 1'b0;
  logic        convStart, tempChannelEnable, refBufferEnable, clearRequest;
  logic [11:0] alarmEvents, groupRange, groupClamp;
  logic [11:0] rangeStrap = 12'h123;
  logic [7:0]  generalPinIn, generalPinOut, generalPinOe;
  logic [7:0]  extLow = 8'h00;
  int          errors = 0;
  int          check_count = 0;
  int          startCnt = 0;
  int          evCnt [12];

  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    startCnt <= startCnt + int'(convStart);
    for (int i = 0; i < 12; i++) evCnt[i] <= evCnt[i] + int'(alarmEvents[i]);
  end

  monitor_alarm_filter_gpio DUT (.sys_clk, .sys_rst, .clkEn, .regAddr,
    .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid, .convValid,
    .convChannel, .convAboveHigh, .convBelowLow, .convData, .convDone,
    .convStart, .tempChannelEnable, .refBufferEnable, .alarmEvents,
    .clearRequest, .rangeStrap, .groupRange, .groupClamp, .generalPinIn,
    .generalPinOut, .generalPinOe);

  pin_pullup_model board (.generalPinOe, .extLow, .generalPinIn);

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge sys_clk);
    regWrEn   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 cmp({3'h0, regRdValid, regRdData}, {4'h1, exp});
  endtask : rd

  task automatic smp(input logic [2:0] ch, input logic hi, input logic lo,
                     input logic [11:0] d);
    @(posedge sys_clk);
    convValid     <= 1'b1;
    convChannel   <= ch;
    convAboveHigh <= hi;
    convBelowLow  <= lo;
    convData      <= d;
    @(posedge sys_clk);
    convValid     <= 1'b0;
  endtask : smp

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : ticks

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask : note

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(OFFS[i], RSTS[i]);
    cmp({11'h0, refBufferEnable}, 12'h000);
    cmp(groupRange, 12'h123);
    note("reset");
    wr(8'h10, 8'h02);
    wr(8'h1E, 8'h56);
    wr(8'h1F, 8'h65);
    ticks(2);
    cmp({11'h0, refBufferEnable}, 12'h001);
    cmp(groupRange, 12'hD6E);
    cmp(groupClamp, 12'h123);
    rd(8'h1F, 8'h65);
    note("config");
    wr(8'h11, 8'h02);
    for (int i = 0; i < 9; i++) begin
      smp(SEQ[i][4:2], SEQ[i][1], SEQ[i][0], 12'h000);
      if (i == 4) begin
        ticks(3);
        cmp(12'(evCnt[2]), 12'h000);
      end
    end
    ticks(3);
    cmp(12'(evCnt[2]), 12'h001);
    cmp(12'(evCnt[5]), 12'h000);
    clkEn <= 1'b0;
    wr(8'h11, 8'h55);
    clkEn <= 1'b1;
    rd(8'h11, 8'h02);
    note("filter");
    smp(3'h5, 1'b0, 1'b0, 12'h028);
    smp(3'h5, 1'b1, 1'b0, 12'hF60);
    smp(3'h5, 1'b0, 1'b0, 12'hF60);
    rd(8'h78, 8'h60);
    rd(8'h79, 8'h0F);
    wr(8'h15, 8'h00);
    ticks(2);
    cmp({11'h0, tempChannelEnable}, 12'h000);
    smp(3'h5, 1'b1, 1'b0, 12'h028);
    ticks(3);
    rd(8'h78, 8'h60);
    cmp(12'(evCnt[10]), 12'h001);
    note("temperature");
    wr(8'h7A, 8'h0F);
    extLow <= 8'h04;
    ticks(2);
    cmp({4'h0, generalPinOe}, 12'h0F0);
    rd(8'h7A, 8'h0B);
    @(posedge sys_clk);
    extLow <= 8'h00;
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h0F);
    cmp({11'h0, generalPinOe[1]}, 12'h001);
    cmp({4'h0, generalPinOut}, 12'h000);
    @(posedge sys_clk);
    extLow <= 8'h05;
    ticks(4);
    cmp({11'h0, clearRequest}, 12'h001);
    cmp(12'(startCnt), 12'h001);
    @(posedge sys_clk);
    convDone <= 1'b1;
    @(posedge sys_clk);
    convDone <= 1'b0;
    ticks(2);
    cmp({11'h0, generalPinOe[3]}, 12'h001);
    rd(8'h78, 8'h60);
    ticks(2);
    cmp({11'h0, generalPinOe[3]}, 12'h000);
    wr(8'h10, 8'h06);
    ticks(3);
    cmp(12'(startCnt), 12'h002);
    note("pins");
    complete_run();
  end
endmodule : monitor_alarm_filter_gpio_bench
